/* mme_baud_div.sv */
`timescale 1ns/100ps
`default_nettype none
module mme_baud_div
    import mme_pkg::*;
#(
    parameter int unsigned DIV = BIT_CYCLES
) (
    input  wire logic sys_clk,  // system clock
    input  wire logic srst,     // synchronous reset
    input  wire logic restart,  // align bit grid to this cycle
    output logic      midTick,  // middle of a bit
    output logic      bitTick   // end of a bit
);
    localparam int unsigned CW = $clog2(DIV);

    logic [CW-1:0] cnt_r;

    // ------------------------------------------------------------------
    // free counter, realigned at each start bit
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (srst || restart || bitTick) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    assign midTick = (cnt_r == CW'(DIV / 2 - 1));
    assign bitTick = (cnt_r == CW'(DIV - 1));
endmodule : mme_baud_div
`default_nettype wire

/* mme_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module mme_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             sys_clk,  // system clock
    input  wire logic             srst,     // synchronous reset
    input  wire logic             inValid,  // write offered
    output logic                  inReady,  // room for a word
    input  wire logic [WIDTH-1:0] inData,   // word written
    output logic                  outValid, // word available
    input  wire logic             outReady, // reader takes word
    output logic      [WIDTH-1:0] outData   // oldest word
);
    localparam int unsigned AW = $clog2(DEPTH);
    localparam int unsigned CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wrPtr_r;
    logic [AW-1:0]    rdPtr_r;
    logic [CW-1:0]    count_r;
    logic             doPush;
    logic             doPop;

    assign inReady  = (count_r != CW'(DEPTH));
    assign outValid = (count_r != '0);
    assign doPush   = inValid && inReady;
    assign doPop    = outValid && outReady;
    assign outData  = mem_r[rdPtr_r];

    // ------------------------------------------------------------------
    // storage and pointers; depth need not be a power of two
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk) begin
        if (doPush) begin
            mem_r[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end else begin
            if (doPush) begin
                wrPtr_r <= (wrPtr_r == AW'(DEPTH - 1)) ? '0 : wrPtr_r + 1'b1;
            end
            if (doPop) begin
                rdPtr_r <= (rdPtr_r == AW'(DEPTH - 1)) ? '0 : rdPtr_r + 1'b1;
            end
            if (doPush && !doPop) begin
                count_r <= count_r + 1'b1;
            end else if (doPop && !doPush) begin
                count_r <= count_r - 1'b1;
            end
        end
    end
endmodule : mme_fifo
`default_nettype wire

/* mme_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// host computer on the single-wire monitor link
// ------------------------------------------------------------------
module mme_host_model #(
    parameter int unsigned BIT_CYC = 16
) (
    input  wire logic sys_clk,   // system clock
    input  wire logic lineLevel, // resolved serial wire
    output logic      hostLow    // host pulls the wire low
);
    logic [8:0] rxQ[$]; // received bytes, bit 8 marks a break

    initial begin
        hostLow = 1'b0;
    end

    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        // two idle bits first: a break still drives its high bit after
        // the host has seen it, and a start bit then would be missed
        repeat (2 * BIT_CYC) @(posedge sys_clk);
        for (int i = 0; i < 10; i++) begin
            hostLow <= ~f[i];
            repeat (BIT_CYC) @(posedge sys_clk);
        end
    endtask : send_byte

    // receiver samples mid-bit; a low stop bit means a break
    // the device may answer inside our own stop bit, so only our own
    // pull-down, not the whole send, masks a falling edge
    initial begin
        logic [7:0] d;
        forever begin
            @(negedge lineLevel);
            if (!hostLow) begin
                repeat (BIT_CYC / 2) @(posedge sys_clk);
                for (int i = 0; i < 8; i++) begin
                    repeat (BIT_CYC) @(posedge sys_clk);
                    d[i] = lineLevel;
                end
                repeat (BIT_CYC) @(posedge sys_clk);
                rxQ.push_back({~lineLevel, d});
                if (!lineLevel) begin
                    @(posedge lineLevel);
                end
            end
        end
    end
endmodule : mme_host_model
`default_nettype wire

/* mme_monitor_entry.sv */
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - entry decided once, after power-on reset; monitor link runs 9600 baud
// - test voltage, bypass low, pins 0/1/1: monitor, bus is osc/2
// - test voltage, bypass high, pins 0/1/1: monitor, bus is osc/4
// - normal irq, blank vector, serial high: monitor, bus is osc/4
// - osc/4 monitor entries disable watchdog, talk on serial pin
// - bypass of divide-by-two only with test voltage; 50% duty input
// - read stack pointer command returns high byte then low byte
// - run command is echoed and starts return from interrupt
// - host sends eight security bytes; match grants full access (here a match only sets the flag; commands run either way)
// - break character sent only after all eight security bytes
// - correct security entry sets a readable flag bit
module mme_monitor_entry
    import mme_pkg::*;
#(
    parameter int unsigned BIT_CYC = BIT_CYCLES // cycles per serial bit
) (
    input  wire logic        sys_clk,       // 200 MHz clock
    input  wire logic        srst,          // power-on reset, active high
    input  wire mme_entry_t  entryPins,     // straps at reset release
    input  wire logic [63:0] securityCode,  // stored bytes, first in [7:0]
    input  wire logic [15:0] stackPointer,  // cpu stack pointer
    input  wire logic        serialIn,      // monitor_serial_pin level
    output mme_mode_t        mode,          // entry decision
    output logic             serialOut,     // value driven on serial pin
    output logic             serialOe_n,    // low while driving serial pin
    output logic [7:0]       securityFlags, // ram flag byte
    output logic             rtiStart       // one-cycle: run user program
);
    typedef enum logic [2:0] {
        ST_DECIDE, ST_USER, ST_SEC, ST_BREAK, ST_CMD, ST_ECHO, ST_SPH, ST_SPL
    } mme_state_t;

    mme_state_t  state_r;
    mme_mode_t   mode_r;
    logic [2:0]  secCnt_r;
    logic        secMiss_r;
    logic        secOk_r;
    logic [7:0]  cmd_r;
    logic        breakReq_r;
    logic        rti_r;
    logic        rxBusy_r;
    logic [3:0]  rxCnt_r;
    logic [7:0]  rxShift_r;
    logic        rxValid_r;
    logic        linePrev_r;
    logic        txBusy_r;
    logic [3:0]  txLeft_r;
    logic [10:0] txShift_r;
    logic        txOut_r;
    logic        txOe_n_r;
    logic        midTick;
    logic        bitTick;
    logic        rxStart;
    logic        txStart;
    logic        pushValid;
    logic [7:0]  pushData;
    logic        pushReady;
    logic        popValid;
    logic        popReady;
    logic [7:0]  popData;
    logic        byteMiss;
    mme_mode_t   decided;

    // ------------------------------------------------------------------
    // entry decision
    // ------------------------------------------------------------------
    function automatic mme_mode_t decide(input mme_entry_t p);
        mme_mode_t m;
        logic      selOk;
        m     = '{monitor: 1'b0, busDiv: DIV_BY_4,
                  oscBypass: 1'b0, watchdogOff: 1'b0};
        selOk = !p.entrySelB && p.entrySelA && p.serialLevel;
        if (p.irqAtTestLevel && selOk && !p.dividerBypass) begin
            m.monitor   = 1'b1;
            m.busDiv    = DIV_BY_2;
            m.oscBypass = 1'b1;
        end else if (p.irqAtTestLevel && selOk) begin
            m.monitor     = 1'b1;
            m.watchdogOff = 1'b1;
        end else if (!p.irqAtTestLevel && p.vectorBlank && p.serialLevel)
        begin
            m.monitor     = 1'b1;
            m.watchdogOff = 1'b1;
        end
        return m;
    endfunction : decide

    // one decoder feeds both the mode register and the sequencer
    assign decided = decide(entryPins);

    // decide once
    // straps are sampled after release, only srst starts a new decision
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mode_r <= '{monitor: 1'b0, busDiv: DIV_BY_4,
                        oscBypass: 1'b0, watchdogOff: 1'b0};
        end else if (state_r == ST_DECIDE) begin
            mode_r <= decided;
        end
    end

    // ------------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------------
    assign byteMiss = (rxShift_r != securityCode[8 * secCnt_r +: 8]);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r    <= ST_DECIDE;
            secCnt_r   <= 3'h0;
            secMiss_r  <= 1'b0;
            secOk_r    <= 1'b0;
            cmd_r      <= 8'h00;
            breakReq_r <= 1'b0;
            rti_r      <= 1'b0;
        end else begin
            rti_r <= 1'b0;
            if (txStart && breakReq_r) begin
                breakReq_r <= 1'b0;
            end
            case (state_r)
                ST_DECIDE: begin
                    state_r <= decided.monitor ? ST_SEC : ST_USER;
                end
                ST_USER: begin
                    state_r <= ST_USER;
                end
                ST_SEC: begin
                    if (rxValid_r) begin
                        secMiss_r <= secMiss_r || byteMiss;
                        secCnt_r  <= secCnt_r + 1'b1;
                        if (secCnt_r == SEC_LAST) begin
                            secOk_r    <= !(secMiss_r || byteMiss);
                            breakReq_r <= 1'b1;
                            state_r    <= ST_BREAK;
                        end
                    end
                end
                ST_BREAK: begin
                    if (!breakReq_r && !txBusy_r) begin
                        state_r <= ST_CMD;
                    end
                end
                ST_CMD: begin
                    if (rxValid_r) begin
                        cmd_r   <= rxShift_r;
                        state_r <= ST_ECHO;
                    end
                end
                ST_ECHO: begin
                    if (pushReady) begin
                        rti_r   <= (cmd_r == CMD_RUN);
                        state_r <= (cmd_r == CMD_READ_SP) ? ST_SPH : ST_CMD;
                    end
                end
                ST_SPH: begin
                    if (pushReady) begin
                        state_r <= ST_SPL;
                    end
                end
                ST_SPL: begin
                    if (pushReady) begin
                        state_r <= ST_CMD;
                    end
                end
                default: begin
                    state_r <= ST_DECIDE;
                end
            endcase
        end
    end

    always_comb begin
        pushValid = 1'b1;
        pushData  = cmd_r;
        if (state_r == ST_SPH) begin
            pushData = stackPointer[15:8];
        end else if (state_r == ST_SPL) begin
            pushData = stackPointer[7:0];
        end else if (state_r != ST_ECHO) begin
            pushValid = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // reply queue and bit timing
    // ------------------------------------------------------------------
    // the sequencer waits on pushReady, so a slow line stalls it
    mme_fifo #(.WIDTH(DATA_BITS), .DEPTH(TX_DEPTH)) u_txq (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .inValid  (pushValid),
        .inReady  (pushReady),
        .inData   (pushData),
        .outValid (popValid),
        .outReady (popReady),
        .outData  (popData)
    );

    mme_baud_div #(.DIV(BIT_CYC)) u_baud (
        .sys_clk (sys_clk),
        .srst    (srst),
        .restart (rxStart || txStart),
        .midTick (midTick),
        .bitTick (bitTick)
    );

    // ------------------------------------------------------------------
    // receiver; half duplex, so it is deaf while we transmit
    // ------------------------------------------------------------------
    assign rxStart = mode_r.monitor && !txBusy_r && !rxBusy_r
                     && linePrev_r && !serialIn;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rxBusy_r   <= 1'b0;
            rxCnt_r    <= 4'h0;
            rxShift_r  <= 8'h00;
            rxValid_r  <= 1'b0;
            linePrev_r <= 1'b1;
        end else begin
            rxValid_r  <= 1'b0;
            linePrev_r <= serialIn;
            if (rxStart) begin
                rxBusy_r <= 1'b1;
                rxCnt_r  <= 4'h0;
            end else if (rxBusy_r && midTick) begin
                if (rxCnt_r == 4'h0) begin
                    rxBusy_r <= !serialIn; // glitch, not a start bit
                    rxCnt_r  <= 4'h1;
                end else if (rxCnt_r != STOP_SLOT) begin
                    rxShift_r <= {serialIn, rxShift_r[7:1]};
                    rxCnt_r   <= rxCnt_r + 1'b1;
                end else begin
                    rxBusy_r  <= 1'b0;
                    rxValid_r <= serialIn; // framing error drops byte
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // transmitter; break has priority over queued bytes
    // ------------------------------------------------------------------
    assign txStart  = !txBusy_r && !rxBusy_r && (breakReq_r || popValid);
    assign popReady = !txBusy_r && !rxBusy_r && !breakReq_r;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txBusy_r  <= 1'b0;
            txLeft_r  <= 4'h0;
            txShift_r <= 11'h7ff;
            txOut_r   <= 1'b1;
            txOe_n_r  <= 1'b1;
        end else if (txStart) begin
            txBusy_r  <= 1'b1;
            txLeft_r  <= breakReq_r ? BREAK_BITS : CHAR_BITS;
            txShift_r <= breakReq_r ? 11'h400 : {2'b11, popData, 1'b0};
            txOut_r   <= 1'b0;
            txOe_n_r  <= 1'b0;
        end else if (txBusy_r && bitTick) begin
            if (txLeft_r == 4'h1) begin
                txBusy_r <= 1'b0;
                txOut_r  <= 1'b1;
                txOe_n_r <= 1'b1;
            end else begin
                txShift_r <= {1'b1, txShift_r[10:1]};
                txOut_r   <= txShift_r[1];
                txLeft_r  <= txLeft_r - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs, all from flip-flops
    // ------------------------------------------------------------------
    assign mode       = mode_r;
    assign serialOut  = txOut_r;
    assign serialOe_n = txOe_n_r;
    assign rtiStart   = rti_r;

    always_comb begin
        securityFlags               = 8'h00;
        securityFlags[SEC_FLAG_BIT] = secOk_r;
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_mode_frozen;
        @(posedge sys_clk) disable iff (srst)
        (state_r != ST_DECIDE) && ($past(state_r) != ST_DECIDE)
            |-> $stable(mode_r);
    endproperty
    a_mode_frozen: assert property (p_mode_frozen)
        else $error("mode changed after entry decision");

    // sampled srst keeps the release edge out: mode_r is still in reset
    property p_div2_entry;
        @(posedge sys_clk) disable iff (srst)
        !srst && (state_r == ST_DECIDE) && entryPins.irqAtTestLevel
            && !entryPins.dividerBypass && !entryPins.entrySelB
            && entryPins.entrySelA && entryPins.serialLevel
            |=> mode_r.monitor && (mode_r.busDiv == DIV_BY_2);
    endproperty
    a_div2_entry: assert property (p_div2_entry)
        else $error("high-voltage bypass entry not divide by two");

    property p_div4_entry;
        @(posedge sys_clk) disable iff (srst)
        !srst && (state_r == ST_DECIDE) && entryPins.irqAtTestLevel
            && entryPins.dividerBypass && !entryPins.entrySelB
            && entryPins.entrySelA && entryPins.serialLevel
            |=> mode_r.monitor && (mode_r.busDiv == DIV_BY_4);
    endproperty
    a_div4_entry: assert property (p_div4_entry)
        else $error("high-voltage entry not divide by four");

    property p_low_entry;
        @(posedge sys_clk) disable iff (srst)
        !srst && (state_r == ST_DECIDE) && !entryPins.irqAtTestLevel
            && entryPins.vectorBlank && entryPins.serialLevel
            |=> mode_r.monitor && (mode_r.busDiv == DIV_BY_4)
                && (state_r == ST_SEC);
    endproperty
    a_low_entry: assert property (p_low_entry)
        else $error("blank vector entry missed");

    property p_wd_off;
        @(posedge sys_clk) disable iff (srst)
        mode_r.monitor && (mode_r.busDiv == DIV_BY_4) |-> mode_r.watchdogOff;
    endproperty
    a_wd_off: assert property (p_wd_off)
        else $error("watchdog left on in divide by four monitor");

    property p_bypass_hv;
        @(posedge sys_clk) disable iff (srst)
        mode_r.oscBypass |-> mode_r.monitor && (mode_r.busDiv == DIV_BY_2);
    endproperty
    a_bypass_hv: assert property (p_bypass_hv)
        else $error("divider bypass outside test entry");

    property p_sp_order;
        @(posedge sys_clk) disable iff (srst)
        (state_r == ST_SPH) && pushReady
            |-> (pushData == stackPointer[15:8]) ##1 (state_r == ST_SPL);
    endproperty
    a_sp_order: assert property (p_sp_order)
        else $error("stack pointer high byte not first");

    property p_run_rti;
        @(posedge sys_clk) disable iff (srst)
        (state_r == ST_ECHO) && pushReady && (cmd_r == CMD_RUN)
            |=> rtiStart ##1 !rtiStart;
    endproperty
    a_run_rti: assert property (p_run_rti)
        else $error("run command did not pulse rti");

    property p_break_after_sec;
        @(posedge sys_clk) disable iff (srst)
        $rose(breakReq_r) |-> ($past(secCnt_r) == SEC_LAST)
            && $past(rxValid_r) && (state_r == ST_BREAK);
    endproperty
    a_break_after_sec: assert property (p_break_after_sec)
        else $error("break sent before eight security bytes");

    property p_start_bit;
        @(posedge sys_clk) disable iff (srst)
        txStart |=> !serialOut && !serialOe_n;
    endproperty
    a_start_bit: assert property (p_start_bit)
        else $error("frame did not open with driven start bit");
endmodule : mme_monitor_entry
`default_nettype wire

/* mme_pkg.sv */
package mme_pkg;

    // ------------------------------------------------------------------
    // serial timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_HZ     = 200_000_000; // sys_clk rate
    localparam int unsigned BAUD_RATE  = 9600;        // monitor link rate
    localparam int unsigned BIT_CYCLES = CLK_HZ / BAUD_RATE;
    localparam int unsigned DATA_BITS  = 8;
    localparam logic [3:0]  CHAR_BITS  = 4'ha;   // start, 8 data, stop
    localparam logic [3:0]  BREAK_BITS = 4'hb;   // 10 low bits, then high
    localparam logic [3:0]  STOP_SLOT  = 4'h9;   // receive slot of stop

    // ------------------------------------------------------------------
    // security and commands
    // ------------------------------------------------------------------
    localparam int unsigned SEC_BYTES    = 8;
    localparam logic [2:0]  SEC_LAST     = 3'h7;
    localparam int unsigned SEC_FLAG_BIT = 6;     // flag bit in ram byte
    localparam logic [7:0]  CMD_READ_SP  = 8'h0c; // read_stack_pointer_cmd
    localparam logic [7:0]  CMD_RUN      = 8'h28; // return_from_interrupt
    localparam int unsigned TX_DEPTH     = 8;

    typedef enum logic { DIV_BY_2, DIV_BY_4 } mme_div_t;

    // pin levels seen at the end of power-on reset
    typedef struct packed {
        logic irqAtTestLevel; // irq pin at test_high_voltage_level
        logic vectorBlank;    // reset vector reads all ones
        logic dividerBypass;  // divider_bypass_pin
        logic entrySelB;      // entry_select_pin_b
        logic entrySelA;      // entry_select_pin_a
        logic serialLevel;    // monitor_serial_pin
    } mme_entry_t;

    // outcome of the entry decision
    typedef struct packed {
        logic     monitor;     // monitor mode, else user mode
        mme_div_t busDiv;      // bus clock from oscillator_input_pin
        logic     oscBypass;   // base clock equals double-rate clock
        logic     watchdogOff; // watchdog_module disabled
    } mme_mode_t;

endpackage : mme_pkg

/* testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------------
// monitor entry and command bench
// ------------------------------------------------------------------
module testbench
    import mme_pkg::*;
;
    localparam int unsigned BC    = 16; // short bit time for sims
    localparam logic [63:0] CODE  = 64'h8877665544332211;
    localparam int          LIMIT = 40000;
    logic         sys_clk = 1'b0;
    logic         srst;
    mme_entry_t   entryPins;
    logic [63:0]  securityCode;
    logic [15:0]  stackPointer;
    wire logic    serialIn;
    mme_mode_t    mode;
    logic         serialOut;
    logic         serialOe_n;
    logic [7:0]   securityFlags;
    logic         rtiStart;
    logic         hostLow;
    int n_errors = 0, checks = 0, cyc = 0, rtiCount = 0;

    // wire has a pull-up, either side may pull it low
    assign serialIn = ~((~serialOe_n & ~serialOut) | hostLow);

    mme_monitor_entry #(.BIT_CYC(BC)) u_dut (
        .sys_clk(sys_clk), .srst(srst), .entryPins(entryPins),
        .securityCode(securityCode), .stackPointer(stackPointer),
        .serialIn(serialIn), .mode(mode), .serialOut(serialOut),
        .serialOe_n(serialOe_n), .securityFlags(securityFlags),
        .rtiStart(rtiStart));
    mme_host_model #(.BIT_CYC(BC)) u_host (
        .sys_clk(sys_clk), .lineLevel(serialIn), .hostLow(hostLow));

    always #2.5 sys_clk = ~sys_clk;

    // cycle ceiling cuts a hang short; pulse counter for run command
    always @(posedge sys_clk) begin
        cyc++;
        if (rtiStart === 1'b1) rtiCount++;
        if (cyc == LIMIT) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic ok, input string msg);
        checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("ERROR at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic do_reset(input mme_entry_t pins);
        entryPins <= pins;
        srst <= 1'b1;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        repeat (3) @(posedge sys_clk);
        u_host.rxQ.delete();
    endtask : do_reset

    // bounded wait for one byte at the host
    task automatic expect_rx(input logic [8:0] exp);
        int n;
        n = 0;
        while (u_host.rxQ.size() == 0 && n < 24 * BC) begin
            @(posedge sys_clk);
            n++;
        end
        check(u_host.rxQ.size() > 0 && u_host.rxQ[0] === exp, "rx byte");
        if (u_host.rxQ.size() > 0) void'(u_host.rxQ.pop_front());
    endtask : expect_rx

    task automatic test_entry();
        mme_entry_t pins[6] = '{6'b100011, 6'b101011, 6'b010001,
                                6'b000001, 6'b100111, 6'b010000};
        logic [3:0] exp[6] = '{4'b1010, 4'b1101, 4'b1101,
                               4'b0100, 4'b0100, 4'b0100};
        for (int i = 0; i < 6; i++) begin
            do_reset(pins[i]);
            check(mode === exp[i], "mode");
            check(serialOe_n === 1'b1, "oe idle");
        end
        $display("test_entry done");
    endtask : test_entry

    task automatic test_security(input logic good);
        do_reset(6'b010001);
        for (int i = 0; i < 7; i++) u_host.send_byte(CODE[8*i +: 8]);
        repeat (12 * BC) @(posedge sys_clk);
        check(u_host.rxQ.size() == 0, "early tx");
        u_host.send_byte(CODE[63:56] ^ {7'h0, ~good});
        expect_rx(9'h100);
        check(securityFlags[SEC_FLAG_BIT] === good, "flag");
        $display("test_security done");
    endtask : test_security

    task automatic test_cmds();
        u_host.send_byte(CMD_READ_SP);
        expect_rx({1'b0, CMD_READ_SP});
        expect_rx({1'b0, stackPointer[15:8]});
        expect_rx({1'b0, stackPointer[7:0]});
        rtiCount = 0;
        u_host.send_byte(CMD_RUN);
        expect_rx({1'b0, CMD_RUN});
        check(rtiCount == 1, "run pulse");
        u_host.send_byte(8'h5a);
        expect_rx(9'h05a);
        check(rtiCount == 1, "stray pulse");
        $display("test_cmds done");
    endtask : test_cmds

    task automatic report_and_stop();
        $display("checks=%0d n_errors=%0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        srst = 1'b1;
        entryPins = '0;
        securityCode = CODE;
        stackPointer = 16'h3ec1;
        test_entry();
        test_security(1'b0);
        test_security(1'b1);
        test_cmds();
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
